// file: include/fmsd_pkg.sv
// constants and carrier types for the floating multiply/subtract datapath
// assumes one processor clock; operands are ones-complement words
package fmsd_pkg;

   ////////////////////////////////////////////////////////////////////////
   // word layout
   localparam int WORD_W = 36;
   localparam int DWORD_W = 72;
   localparam int SP_SIGN = 35;
   localparam int SP_CHAR_MSB = 34;
   localparam int SP_CHAR_LSB = 27;
   localparam int SP_CHAR_W = 8;
   localparam int DP_SIGN = 71;
   localparam int DP_CHAR_MSB = 70;
   localparam int DP_CHAR_LSB = 60;
   localparam int DP_CHAR_W = 11;

   ////////////////////////////////////////////////////////////////////////
   // mantissa multiply geometry
   localparam int SP_ITER = 14;
   localparam int DP_ITER = 30;
   localparam int CNT_W = 5;
   localparam int SP_TERM_SH = 36;
   localparam int SP_NORM_BIT = 62;
   localparam int DP_NORM_BIT = 59;
   localparam int LO_SHIFT = 9;

   ////////////////////////////////////////////////////////////////////////
   // characteristic adders and bias figures (octal in comments)
   localparam int SP_ADDER_W = 9;
   localparam int DP_ADDER_W = 12;
   localparam logic [8:0] SP_SUB_HI = 9'h080;    // 200
   localparam logic [8:0] SP_SUB_HI_NS = 9'h081; // 201
   localparam logic [8:0] SP_SUB_LO = 9'h09B;    // 233
   localparam logic [8:0] SP_SUB_LO_NS = 9'h09C; // 234
   localparam logic [8:0] SP_CHAR_MAX = 9'h0FF;  // 377
   localparam logic [11:0] DP_SUB = 12'h400;     // 2000
   localparam logic [11:0] DP_SUB_NS = 12'h401;  // 2001
   localparam logic [11:0] DP_CHAR_MAX = 12'h7FF; // 3777

   ////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [1:0] {OP_ADD, OP_SUB, OP_MUL} fmsd_op_t;
   typedef enum logic [1:0] {FLT_NONE, FLT_OVF, FLT_UNF, FLT_ABORT}
      fmsd_fault_t;
   typedef enum logic [2:0] {ST_IDLE, ST_MULT, ST_EXTRA, ST_NORM, ST_PACK,
      ST_ADDW} fmsd_phase_t;

   typedef struct packed {
      fmsd_op_t op;
      logic dp;
      logic [DWORD_W-1:0] a;
      logic [DWORD_W-1:0] b;
   } fmsd_req_t;

   typedef struct packed {
      logic dp;
      logic [DWORD_W-1:0] a;
      logic [DWORD_W-1:0] b;
   } fmsd_addreq_t;

   typedef struct packed {
      logic [WORD_W-1:0] hi;
      logic [WORD_W-1:0] lo;
      fmsd_fault_t fault;
   } fmsd_rsp_t;

   typedef struct packed {
      fmsd_phase_t phase;
      logic dp;
      logic neg;
      logic keep;
      logic supp;
      logic shifted;
      logic carry;
      logic [CNT_W-1:0] cnt;
      logic [DP_CHAR_W-1:0] ca;
      logic [DP_CHAR_W-1:0] cb;
      logic [DWORD_W-1:0] mcand;
      logic [DWORD_W-1:0] mplier;
      logic [DWORD_W-1:0] acc;
      logic busy;
      logic done;
      logic add_vld;
      fmsd_addreq_t add_req;
      fmsd_rsp_t rsp;
   } fmsd_regs_t;

endpackage

// file: rtl/fmsd_char_arith.sv
// characteristic adder: sum of two saved characteristics less a bias
// assumes characteristics are already made positive by the caller
`timescale 1ns/1ps
module fmsd_char_arith
#(
   parameter int W = 9
)
(
   // saved operand characteristics
   input wire logic [W-2:0] char_a,
   input wire logic [W-2:0] char_b,
   // bias to take off and largest legal result
   input wire logic [W-1:0] bias,
   input wire logic [W-1:0] limit,
   // result and range flags
   output logic [W-1:0] char_out,
   output logic ovf,
   output logic unf
);

   logic [W-1:0] sum;
   logic [W:0] diff;

   if (W < 3)
   begin : g_bad_width
      $error("fmsd_char_arith: width too small");
   end

   ////////////////////////////////////////////////////////////////////////
   // one extra bit carries the sign of the difference
   always_comb
   begin
      sum = {1'b0, char_a} + {1'b0, char_b};
      diff = {1'b0, sum} - {1'b0, bias};
      unf = diff[W];
      ovf = !diff[W] && (diff[W-1:0] > limit);
      char_out = diff[W-1:0];
   end

endmodule

// file: rtl/fmsd_datapath.sv
// floating subtract and multiply datapath for ones-complement words
// assumes the control section holds req stable with the start pulse and
// that an external floating adder answers add_req with one add_rsp_vld
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - subtract: adder gets complemented subtrahend
// - difference normalized by adder, residue unchecked
// - unnormalized multiply inputs give unspecified result
// - single multiply loads two 36-bit operands
// - product sign from operand signs, zero is +0 unless keep bit
// - clear single characteristic fields and accumulator
// - fourteen radix-four steps, then one left shift
// - rotate left until bit 62 set
// - nine-bit adder sums characteristics, bias 400
// - no shift: take off 200 and 233
// - shifted: take off 201 and 234
// - nonzero high word: overflow or underflow aborts
// - pack high characteristic, complement if signs differ
// - zero high mantissa: clear unless keep bit
// - zero mantissa range error: no fault raised
// - low word: shift nine, insert characteristic, complement
// - low underflow clears to +0, keep bit ignored
// - double multiply loads 72-bit, clears 70..60
// - thirty steps, extra add on final 11
// - keep top sixty bits, rotate if bit 59 clear
// - twelve-bit adder, take off 2000 or 2001
// - double overflow aborts; underflow faults or clears
// - zero double product +0, else pack, complement
module fmsd_datapath
#(
   parameter int SP_STEPS = fmsd_pkg::SP_ITER,
   parameter int DP_STEPS = fmsd_pkg::DP_ITER
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // request from the control section
   input wire logic start,
   input wire fmsd_pkg::fmsd_req_t req,
   // processor state bits
   input wire logic keep_char_on_zero_mantissa,
   input wire logic dp_underflow_suppress,
   // answer to the control section
   output logic busy,
   output logic done,
   output fmsd_pkg::fmsd_rsp_t rsp,
   // floating adder shared with addition
   output logic add_req_vld,
   output fmsd_pkg::fmsd_addreq_t add_req,
   input wire logic add_rsp_vld,
   input wire fmsd_pkg::fmsd_rsp_t add_rsp
);

   localparam logic [4:0] SP_LAST = 5'(SP_STEPS - 1);
   localparam logic [4:0] DP_LAST = 5'(DP_STEPS - 1);
   localparam int W = fmsd_pkg::WORD_W;
   localparam int DW = fmsd_pkg::DWORD_W;

   if (SP_STEPS != fmsd_pkg::SP_ITER || DP_STEPS < 1
      || DP_STEPS > fmsd_pkg::DP_ITER)
   begin : g_bad_steps
      $error("fmsd_datapath: step counts the datapath cannot serve");
   end

   fmsd_pkg::fmsd_regs_t s_q;
   fmsd_pkg::fmsd_regs_t s_d;

   logic [DW-1:0] term;
   logic [DW-1:0] step_acc;
   logic step_carry;
   logic in_extra;
   logic [8:0] chi;
   logic [8:0] clo;
   logic [11:0] cdp;
   logic hi_ovf;
   logic hi_unf;
   logic lo_unf;
   logic dp_ovf;
   logic dp_unf;
   logic hi_mant_zero;
   logic in_mult;

   ////////////////////////////////////////////////////////////////////////
   // conditional ones complement, used on operands and results
   function automatic logic [71:0] cmp_if(input logic [71:0] x,
      input logic neg);
      cmp_if = neg ? ~x : x;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // shared multiply step; single precision adds at the upper position
   assign in_extra = s_q.phase == fmsd_pkg::ST_EXTRA;
   assign in_mult = s_q.phase == fmsd_pkg::ST_MULT;
   assign term = s_q.dp ? s_q.mcand : (s_q.mcand << fmsd_pkg::SP_TERM_SH);

   fmsd_mul_step u_step
   (
      .acc(s_q.acc),
      .term(term),
      .pair(in_extra ? 2'b00 : s_q.mplier[1:0]),
      .carry_in(s_q.carry),
      .shift_en(!in_extra),
      .acc_next(step_acc),
      .carry_out(step_carry)
   );

   ////////////////////////////////////////////////////////////////////////
   // characteristic arithmetic for both words and both precisions
   fmsd_char_arith #(.W(fmsd_pkg::SP_ADDER_W)) u_char_hi
   (
      .char_a(s_q.ca[fmsd_pkg::SP_CHAR_W-1:0]),
      .char_b(s_q.cb[fmsd_pkg::SP_CHAR_W-1:0]),
      .bias(s_q.shifted ? fmsd_pkg::SP_SUB_HI_NS : fmsd_pkg::SP_SUB_HI),
      .limit(fmsd_pkg::SP_CHAR_MAX),
      .char_out(chi),
      .ovf(hi_ovf),
      .unf(hi_unf)
   );

   fmsd_char_arith #(.W(fmsd_pkg::SP_ADDER_W)) u_char_lo
   (
      .char_a(s_q.ca[fmsd_pkg::SP_CHAR_W-1:0]),
      .char_b(s_q.cb[fmsd_pkg::SP_CHAR_W-1:0]),
      .bias(s_q.shifted ? fmsd_pkg::SP_SUB_LO_NS : fmsd_pkg::SP_SUB_LO),
      .limit(fmsd_pkg::SP_CHAR_MAX),
      .char_out(clo),
      .ovf(),
      .unf(lo_unf)
   );

   fmsd_char_arith #(.W(fmsd_pkg::DP_ADDER_W)) u_char_dp
   (
      .char_a(s_q.ca),
      .char_b(s_q.cb),
      .bias(s_q.shifted ? fmsd_pkg::DP_SUB_NS : fmsd_pkg::DP_SUB),
      .limit(fmsd_pkg::DP_CHAR_MAX),
      .char_out(cdp),
      .ovf(dp_ovf),
      .unf(dp_unf)
   );

   assign hi_mant_zero = s_q.acc[fmsd_pkg::SP_NORM_BIT:W] == '0;

   ////////////////////////////////////////////////////////////////////////
   // sequencer: unpack, multiply, normalize, pack, or hand to the adder
   always_comb
   begin
      logic [DW-1:0] pa;
      logic [DW-1:0] pb;
      logic [DW-1:0] wd;
      logic [W-1:0] wh;
      logic [W-1:0] wl;
      logic sa;
      logic sb;
      pa = '0;
      pb = '0;
      wd = '0;
      wh = '0;
      wl = '0;
      sa = 1'b0;
      sb = 1'b0;
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.add_vld = 1'b0;
      case (s_q.phase)
         fmsd_pkg::ST_IDLE:
         begin
            if (start)
            begin
               s_d.busy = 1'b1;
               s_d.dp = req.dp;
               s_d.keep = keep_char_on_zero_mantissa;
               s_d.supp = dp_underflow_suppress;
               case (req.op)
                  fmsd_pkg::OP_MUL:
                  begin
                     // no normalization check on inputs; the result for
                     // unnormalized operands is simply what falls out
                     sa = req.dp ? req.a[fmsd_pkg::DP_SIGN]
                        : req.a[fmsd_pkg::SP_SIGN];
                     sb = req.dp ? req.b[fmsd_pkg::DP_SIGN]
                        : req.b[fmsd_pkg::SP_SIGN];
                     s_d.neg = sa ^ sb;
                     pa = cmp_if(req.a, sa);
                     pb = cmp_if(req.b, sb);
                     s_d.acc = '0;
                     s_d.carry = 1'b0;
                     s_d.cnt = '0;
                     s_d.shifted = 1'b0;
                     s_d.phase = fmsd_pkg::ST_MULT;
                     if (req.dp)
                     begin
                        // characteristics saved, fields cleared
                        s_d.ca = pa[fmsd_pkg::DP_CHAR_MSB:
                           fmsd_pkg::DP_CHAR_LSB];
                        s_d.cb = pb[fmsd_pkg::DP_CHAR_MSB:
                           fmsd_pkg::DP_CHAR_LSB];
                        s_d.mcand = {12'h000,
                           pa[fmsd_pkg::DP_CHAR_LSB-1:0]};
                        s_d.mplier = {12'h000,
                           pb[fmsd_pkg::DP_CHAR_LSB-1:0]};
                     end
                     else
                     begin
                        // 36-bit operands in the low word
                        s_d.ca = {3'h0, pa[fmsd_pkg::SP_CHAR_MSB:
                           fmsd_pkg::SP_CHAR_LSB]};
                        s_d.cb = {3'h0, pb[fmsd_pkg::SP_CHAR_MSB:
                           fmsd_pkg::SP_CHAR_LSB]};
                        s_d.mcand = {45'h0,
                           pa[fmsd_pkg::SP_CHAR_LSB-1:0]};
                        s_d.mplier = {45'h0,
                           pb[fmsd_pkg::SP_CHAR_LSB-1:0]};
                     end
                  end
                  fmsd_pkg::OP_ADD, fmsd_pkg::OP_SUB:
                  begin
                     // subtraction reuses the add path with operand b complemented
                     s_d.add_vld = 1'b1;
                     s_d.add_req.dp = req.dp;
                     s_d.add_req.a = req.a;
                     s_d.add_req.b = req.b;
                     if (req.op == fmsd_pkg::OP_SUB)
                     begin
                        s_d.add_req.b = req.dp ? ~req.b
                           : {36'h0, ~req.b[W-1:0]};
                     end
                     s_d.phase = fmsd_pkg::ST_ADDW;
                  end
                  default:
                  begin
                     // unknown code answers at once with abort
                     s_d.rsp = '{hi: '0, lo: '0,
                        fault: fmsd_pkg::FLT_ABORT};
                     s_d.done = 1'b1;
                     s_d.busy = 1'b0;
                  end
               endcase
            end
         end
         fmsd_pkg::ST_MULT:
         begin
            // two multiplier bits per major cycle
            s_d.acc = step_acc;
            s_d.carry = step_carry;
            s_d.mplier = s_q.mplier >> 2;
            s_d.cnt = s_q.cnt + 5'h01;
            if (!s_q.dp && s_q.cnt == SP_LAST)
            begin
               s_d.acc = {step_acc[DW-2:0], 1'b0};
               s_d.phase = fmsd_pkg::ST_NORM;
            end
            else if (s_q.dp && s_q.cnt == DP_LAST)
            begin
               // a final 11 pair leaves a carry: one more add
               s_d.phase = step_carry ? fmsd_pkg::ST_EXTRA
                  : fmsd_pkg::ST_NORM;
            end
         end
         fmsd_pkg::ST_EXTRA:
         begin
            s_d.acc = step_acc;
            s_d.carry = 1'b0;
            s_d.phase = fmsd_pkg::ST_NORM;
         end
         fmsd_pkg::ST_NORM:
         begin
            // a zero product would never set the bit, so it is skipped
            if (s_q.dp)
            begin
               if (s_q.acc != '0 && !s_q.acc[fmsd_pkg::DP_NORM_BIT])
               begin
                  s_d.acc = {s_q.acc[DW-2:0], s_q.acc[DW-1]};
                  s_d.shifted = 1'b1;
               end
               s_d.phase = fmsd_pkg::ST_PACK;
            end
            else if (s_q.acc != '0 && !s_q.acc[fmsd_pkg::SP_NORM_BIT])
            begin
               s_d.acc = {s_q.acc[DW-2:0], s_q.acc[DW-1]};
               s_d.shifted = 1'b1;
            end
            else
            begin
               s_d.phase = fmsd_pkg::ST_PACK;
            end
         end
         fmsd_pkg::ST_PACK:
         begin
            s_d.rsp.fault = fmsd_pkg::FLT_NONE;
            if (s_q.dp)
            begin
               if (s_q.acc == '0)
               begin
                  wd = '0;
               end
               else if (dp_ovf)
               begin
                  s_d.rsp.fault = fmsd_pkg::FLT_OVF;
               end
               else if (dp_unf)
               begin
                  // suppressed underflow stores +0 instead
                  if (!s_q.supp)
                  begin
                     s_d.rsp.fault = fmsd_pkg::FLT_UNF;
                  end
               end
               else
               begin
                  wd = cmp_if({1'b0, cdp[fmsd_pkg::DP_CHAR_W-1:0],
                     s_q.acc[fmsd_pkg::DP_CHAR_LSB-1:0]},
                     s_q.neg);
               end
               s_d.rsp.hi = wd[DW-1:W];
               s_d.rsp.lo = wd[W-1:0];
            end
            else if (!hi_mant_zero && hi_ovf)
            begin
               s_d.rsp = '{hi: '0, lo: '0,
                  fault: fmsd_pkg::FLT_OVF};
            end
            else if (!hi_mant_zero && hi_unf)
            begin
               s_d.rsp = '{hi: '0, lo: '0,
                  fault: fmsd_pkg::FLT_UNF};
            end
            else
            begin
               // high word: characteristic then sign
               wd = cmp_if({36'h0, 1'b0, chi[fmsd_pkg::SP_CHAR_W-1:0],
                  s_q.acc[fmsd_pkg::SP_NORM_BIT:W]}, s_q.neg);
               wh = wd[W-1:0];
               if (hi_mant_zero)
               begin
                  if (!s_q.keep)
                  begin
                     wh = '0;
                  end
                  else if (hi_ovf || hi_unf)
                  begin
                     // characteristic follows the zero mantissa's sign
                     wh = {W{s_q.neg}};
                  end
               end
               // low word, keep bit plays no part
               wd = cmp_if({36'h0, 1'b0, clo[fmsd_pkg::SP_CHAR_W-1:0],
                  s_q.acc[W-1:fmsd_pkg::LO_SHIFT]}, s_q.neg);
               wl = (lo_unf || s_q.acc == '0) ? '0 : wd[W-1:0];
               s_d.rsp.hi = wh;
               s_d.rsp.lo = wl;
            end
            s_d.done = 1'b1;
            s_d.busy = 1'b0;
            s_d.phase = fmsd_pkg::ST_IDLE;
         end
         fmsd_pkg::ST_ADDW:
         begin
            // the adder normalizes the difference; residue as it comes
            if (add_rsp_vld)
            begin
               s_d.rsp = add_rsp;
               s_d.done = 1'b1;
               s_d.busy = 1'b0;
               s_d.phase = fmsd_pkg::ST_IDLE;
            end
         end
         default:
         begin
            s_d.phase = fmsd_pkg::ST_IDLE;
            s_d.busy = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign busy = s_q.busy;
   assign done = s_q.done;
   assign rsp = s_q.rsp;
   assign add_req_vld = s_q.add_vld;
   assign add_req = s_q.add_req;

   ////////////////////////////////////////////////////////////////////////
   // checks, all on the one processor clock
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);

   chk_sub_operand: assert property (
      start && s_q.phase == fmsd_pkg::ST_IDLE && req.op == fmsd_pkg::OP_SUB
      |=> add_req_vld && add_req.b[W-1:0] == ~$past(req.b[W-1:0]))
      else $error("subtrahend not complemented");

   chk_add_pass: assert property (
      s_q.phase == fmsd_pkg::ST_ADDW && add_rsp_vld
      |=> done && rsp == $past(add_rsp))
      else $error("adder answer not returned");

   chk_unpack_clear: assert property (
      in_mult && !s_q.dp |-> s_q.mcand[DW-1:fmsd_pkg::SP_CHAR_LSB] == '0)
      else $error("single multiplicand fields not cleared");

   chk_sp_steps: assert property (
      $rose(in_mult) && !s_q.dp |-> ##13 in_mult ##1 !in_mult)
      else $error("single multiply step count wrong");

   chk_dp_steps: assert property (
      $rose(in_mult) && s_q.dp |-> ##29 in_mult ##1 !in_mult)
      else $error("double multiply step count wrong");

   chk_sp_norm: assert property (
      s_q.phase == fmsd_pkg::ST_PACK && !s_q.dp && s_q.acc != '0
      |-> s_q.acc[fmsd_pkg::SP_NORM_BIT])
      else $error("single product not normalized");

   chk_dp_norm: assert property (
      s_q.phase == fmsd_pkg::ST_PACK && s_q.dp && s_q.acc != '0
      && $past(s_q.acc[fmsd_pkg::DP_NORM_BIT - 1])
      |-> s_q.acc[fmsd_pkg::DP_NORM_BIT])
      else $error("double product not normalized");

   chk_sp_ovf: assert property (
      s_q.phase == fmsd_pkg::ST_PACK && !s_q.dp && !hi_mant_zero && hi_ovf
      |=> done && rsp.fault == fmsd_pkg::FLT_OVF)
      else $error("single overflow not reported");

   chk_dp_zero: assert property (
      s_q.phase == fmsd_pkg::ST_PACK && s_q.dp && s_q.acc == '0
      |=> done && rsp.hi == '0 && rsp.lo == '0
      && rsp.fault == fmsd_pkg::FLT_NONE)
      else $error("zero double product not +0");

   chk_dp_unf_supp: assert property (
      s_q.phase == fmsd_pkg::ST_PACK && s_q.dp && s_q.acc != '0
      && !dp_ovf && dp_unf && s_q.supp
      |=> done && rsp.fault == fmsd_pkg::FLT_NONE && rsp.hi == '0)
      else $error("suppressed underflow not cleared");

   chk_mul_done: assert property (
      start && s_q.phase == fmsd_pkg::ST_IDLE && req.op == fmsd_pkg::OP_MUL
      |-> ##[3:120] done)
      else $error("multiply did not finish");

endmodule

// file: rtl/fmsd_mul_step.sv
// one major cycle of the mantissa multiply: add then optional shift
// assumes positive multiplicand; accumulator is held two's complement
`timescale 1ns/1ps
module fmsd_mul_step
(
   // accumulator and addend
   input wire logic [71:0] acc,
   input wire logic [71:0] term,
   // multiplier pair and pending carry
   input wire logic [1:0] pair,
   input wire logic carry_in,
   input wire logic shift_en,
   // result
   output logic [71:0] acc_next,
   output logic carry_out
);

   logic [2:0] digit;
   logic [71:0] addend;
   logic [71:0] sum;

   ////////////////////////////////////////////////////////////////////////
   // pair 11 is taken as minus one plus a carry, so only 1x and 2x adds
   always_comb
   begin
      digit = {1'b0, pair} + {2'b00, carry_in};
      addend = '0;
      carry_out = 1'b0;
      case (digit)
         3'h1: addend = term;
         3'h2: addend = {term[70:0], 1'b0};
         3'h3:
         begin
            addend = ~term + 72'h1;
            carry_out = 1'b1;
         end
         3'h4: carry_out = 1'b1;
         default: addend = '0;
      endcase
      sum = acc + addend;
      // arithmetic shift keeps a transient negative sum correct
      acc_next = shift_en ? {{2{sum[71]}}, sum[71:2]} : sum;
   end

endmodule

// file: verif/fmsd_adder_model.sv
// behavioural floating adder on the far side of the add port
// assumes one request outstanding; echoes operand b as the sum words
`timescale 1ns/1ps
module fmsd_adder_model
#(
   parameter int LAT = 3
)
(
   // clock and request
   input wire logic ref_clk,
   input wire logic add_req_vld,
   input wire fmsd_pkg::fmsd_addreq_t add_req,
   // answer
   output logic add_rsp_vld,
   output fmsd_pkg::fmsd_rsp_t add_rsp
);
   int cnt = 0;
   initial add_rsp_vld = 1'b0;
   initial add_rsp = '0;
   // slow answer; data toggles outside the valid cycle so stale use shows
   always @(posedge ref_clk)
   begin
      add_rsp_vld <= 1'b0;
      add_rsp <= ~add_rsp;
      if (add_req_vld)
         cnt <= LAT;
      else if (cnt > 0)
         cnt <= cnt - 1;
      if (cnt == 1)
      begin
         add_rsp_vld <= 1'b1;
         add_rsp <= {add_req.b, fmsd_pkg::FLT_NONE};
      end
   end
endmodule

// file: verif/fmsd_datapath_tb.sv
// self-checking bench for the floating multiply/subtract datapath
// assumes the adder model echoes operand b as its result words
`timescale 1ns/1ps
module fmsd_datapath_tb;
   typedef struct {
      fmsd_pkg::fmsd_op_t op;
      logic dp, supp;
      logic [71:0] a, b, res;
      fmsd_pkg::fmsd_fault_t flt;
   } fmsd_row_t;
   logic ref_clk = 1'b0, srst = 1'b1, start = 1'b0, keep = 1'b0, supp = 1'b0;
   fmsd_pkg::fmsd_req_t req = '0;
   logic busy, done, add_req_vld, add_rsp_vld;
   fmsd_pkg::fmsd_rsp_t rsp, add_rsp;
   fmsd_pkg::fmsd_addreq_t add_req;
   int num_errors = 0, n_tests = 0, cyc = 0, i;
   fmsd_row_t rows[12];
   always #2.5 ref_clk = ~ref_clk;
   ////////////////////////////////////////////////////////////////////////
   fmsd_datapath dut (.ref_clk(ref_clk), .srst(srst), .start(start),
      .req(req), .keep_char_on_zero_mantissa(keep),
      .dp_underflow_suppress(supp), .busy(busy), .done(done), .rsp(rsp),
      .add_req_vld(add_req_vld), .add_req(add_req),
      .add_rsp_vld(add_rsp_vld), .add_rsp(add_rsp));
   fmsd_adder_model adder (.ref_clk(ref_clk), .add_req_vld(add_req_vld),
      .add_req(add_req), .add_rsp_vld(add_rsp_vld), .add_rsp(add_rsp));
   ////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      if (num_errors == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk_rsp(input logic [71:0] w, input fmsd_pkg::fmsd_fault_t f);
      n_tests++;
      if ({rsp.hi, rsp.lo} !== w || rsp.fault !== f)
      begin
         num_errors++;
         $display("[FAIL] %0t result %h exp %h", $time, rsp, {w, f});
      end
   endtask
   // hang guard: far above the longest expected run
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         num_errors++;
         end_of_test();
      end
   end
   task automatic chk_busy(input logic e);
      n_tests++;
      if (busy !== e)
      begin
         num_errors++;
         $display("[FAIL] %0t busy %b exp %b", $time, busy, e);
      end
   endtask
   // bounded wait for done; running out counts as a mismatch
   task automatic wait_done();
      int k;
      k = 0;
      while (k < 200 && done !== 1'b1)
      begin
         @(posedge ref_clk) #1;
         k++;
      end
      if (done !== 1'b1)
      begin
         num_errors++;
         $display("[FAIL] %0t no done", $time);
      end
   endtask
   // one request; waits a bounded time for done
   task automatic run(input fmsd_row_t r);
      req = '{r.op, r.dp, r.a, r.b};
      supp = r.supp;
      start = 1'b1;
      @(posedge ref_clk) #1;
      start = 1'b0;
      wait_done();
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      rows = '{
      '{fmsd_pkg::OP_MUL, 0, 0, 'h404000000, 'h404000000,
         'h3FC000000320000000, fmsd_pkg::FLT_NONE},
      '{fmsd_pkg::OP_MUL, 0, 0, 'hBFBFFFFFF, 'h404000000,
         'hC03FFFFFFCDFFFFFFF, fmsd_pkg::FLT_NONE},
      '{fmsd_pkg::OP_MUL, 0, 0, 'h7FC000000, 'h7FC000000, 0, fmsd_pkg::FLT_OVF},
      '{fmsd_pkg::OP_MUL, 0, 0, 'h004000000, 'h004000000, 0, fmsd_pkg::FLT_UNF},
      '{fmsd_pkg::OP_MUL, 1, 0, 'h400800000000000000, 'h400800000000000000,
         'h3FF800000000000000, fmsd_pkg::FLT_NONE},
      '{fmsd_pkg::OP_MUL, 1, 0, 'h000800000000000000, 'h000800000000000000,
         0, fmsd_pkg::FLT_UNF},
      '{fmsd_pkg::OP_MUL, 1, 1, 'h000800000000000000, 'h000800000000000000,
         0, fmsd_pkg::FLT_NONE},
      '{fmsd_pkg::OP_MUL, 1, 0, 0, 'hBFF7FFFFFFFFFFFFFF, 0, fmsd_pkg::FLT_NONE},
      '{fmsd_pkg::OP_SUB, 0, 0, 1, 'h0F0F0F0F0, 'hF0F0F0F0F, fmsd_pkg::FLT_NONE},
      '{fmsd_pkg::OP_SUB, 1, 0, 1, 'h5, 'hFFFFFFFFFFFFFFFFFA, fmsd_pkg::FLT_NONE},
      '{fmsd_pkg::OP_ADD, 0, 0, 1, 'h123456789, 'h123456789, fmsd_pkg::FLT_NONE},
      '{fmsd_pkg::fmsd_op_t'(2'd3), 0, 0, 1, 1, 0, fmsd_pkg::FLT_ABORT}};
      repeat (20) @(posedge ref_clk);
      #1 srst = 1'b0;
      chk_rsp(0, fmsd_pkg::FLT_NONE);
      // table of operations, each row waits for its own done
      for (i = 0; i < 12; i++)
      begin
         run(rows[i]);
         chk_rsp(rows[i].res, rows[i].flt);
      end
      // a second start while busy must be ignored: one done, first result
      req = '{fmsd_pkg::OP_MUL, 1'b0, 72'h404000000, 72'h404000000};
      start = 1'b1;
      @(posedge ref_clk) #1;
      chk_busy(1'b1);
      req.b = 72'h7FC000000;
      @(posedge ref_clk) #1;
      start = 1'b0;
      wait_done();
      chk_rsp(72'h3FC000000320000000, fmsd_pkg::FLT_NONE);
      chk_busy(1'b0);
      // zero high mantissa with the keep bit set: word stays packed
      keep = 1'b1;
      run('{fmsd_pkg::OP_MUL, 1'b0, 1'b0, 72'h404000000, 72'h400000000,
         72'h400000000000000000, fmsd_pkg::FLT_NONE});
      chk_rsp(72'h400000000000000000, fmsd_pkg::FLT_NONE);
      end_of_test();
   end
endmodule
